/* File: rtl/fn_power_pkg.sv */
// package for the function power-state controller: encodings, states, carriers
// assumes a single core_clk domain; used by rtl/function_power_state_control.sv
package fn_power_pkg;
	// power-state field encodings of the power management control/status register
	localparam logic [1:0] PS_D0 = 2'h0;
	localparam logic [1:0] PS_D3 = 2'h3;
	// manageability mode meaning none
	localparam logic [1:0] MNG_MODE_NONE = 2'h0;
	// default number of dma engines (tx and rx)
	localparam int ENGINE_COUNT = 2;
	// width of the outstanding-tlp counter
	localparam int OUTST_W = 8;
	localparam logic [OUTST_W-1:0] OUTST_ZERO = 8'h00;
	localparam logic [OUTST_W-1:0] OUTST_ONE = 8'h01;

	// function power states, gray coded along reset_held -> uninit -> active -> d3hot
	typedef enum logic [1:0] {
		RESET_HELD_STATE = 2'b00,
		UNINITIALIZED_ACTIVE_STATE = 2'b01,
		FULLY_ACTIVE_STATE = 2'b11,
		D3HOT_STATE = 2'b10
	} power_state_t;

	// a configuration write toward the function
	typedef struct packed {
		logic pm_write; // write to power_mgmt_ctrl_status power-state field
		logic [1:0] pm_state;
		logic cmd_write; // write to the command register
		logic mem_enable;
		logic io_enable;
		logic bus_master;
	} cfg_write_t;

	// classification of a received transaction layer packet
	typedef struct packed {
		logic valid;
		logic is_config;
		logic is_message;
		logic is_completion;
	} rx_tlp_t;

	// values loaded from flash at power-up
	typedef struct packed {
		logic valid;
		logic flash_magic_wake_enable;
		logic flash_manageability_enable;
		logic [1:0] manageability_mode;
	} flash_cfg_t;
endpackage : fn_power_pkg

/* File: rtl/function_power_state_control.sv */
// power-state controller of one lan function: power states, master disable, reset-held exchange, disable mode
// assumes cfg writes and tlp events on core_clk; i/o reset and reset-held message pins are synchronised here
//
// The address map and strobed register access were chosen for this implementation.
`timescale 1ns/1ps

// Overview of operation
// - writing D3 encoding to power-state field moves function into D3hot.
// - enabled wake filter settings survive D3hot and reset-held entry unchanged.
// - entering D3hot clears memory and I/O access enable bits.
// - in D3hot only configuration accesses answered; no master cycles.
// - in D3hot non-config, non-message requests are unsupported; completions unexpected.
// - unsupported request received in D3hot sends error message when enabled; unexpected completion does not.
// - from D3hot, writing D0 encoding moves function to uninitialized D0.
// - from D3hot, integrated I/O reset moves function into reset-held state.
// - all functions in D3: stop new TLPs, drain sent ones, clear access enables.
// - unmoved receive packets held in D3, discarded on exit; transmit may continue.
// - after bus master cleared or D3 entry, no further master accesses.
// - master disable blocks new master requests but lets issued ones complete.
// - every reset level clears the master disable bit.
// - master enable status clears only when disabled, engines idle, completions in.
// - power-good starts reset-held; I/O reset release moves to uninitialized D0.
// - power-up reset-held keeps PHYs low power, loads flash, takes magic wake enable from flash.
// - reset-held message: stop TLPs, drain, answer non-posted, then send ready.
// - disable mode only in reset-held with no wake and no manageability.
// - power-up flash meeting conditions enters disable; I/O reset release exits.
// - command memory or I/O enable write moves uninitialized D0 to active.
// - entering uninitialized D0 clears wake event enable and wake filters; magic wake enable kept.
module function_power_state_control #(
	parameter int ENGINES = fn_power_pkg::ENGINE_COUNT
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic io_reset_n,
	input wire logic sw_reset,
	input wire fn_power_pkg::cfg_write_t cfg_wr,
	input wire logic master_disable_wr,
	input wire logic master_disable_val,
	input wire logic wake_event_enable_wr,
	input wire logic wake_event_enable_val,
	input wire logic magic_wake_enable_wr,
	input wire logic magic_wake_enable_val,
	input wire logic [7:0] wake_filter_wr_val,
	input wire logic wake_filter_wr,
	input wire logic error_report_enable,
	input wire fn_power_pkg::rx_tlp_t rx_tlp,
	input wire fn_power_pkg::flash_cfg_t flash_cfg,
	input wire logic other_functions_d3,
	input wire logic reset_held_msg,
	input wire logic [ENGINES-1:0] engine_req,
	input wire logic master_issue,
	input wire logic completion_in,
	input wire logic np_pending,
	output fn_power_pkg::power_state_t power_state,
	output logic mem_enable,
	output logic io_enable,
	output logic bus_master,
	output logic master_disable,
	output logic master_enable_status,
	output logic master_grant,
	output logic tlp_schedule_enable,
	output logic unsupported_request,
	output logic unexpected_completion,
	output logic error_msg_send,
	output logic ready_for_reset_msg,
	output logic wake_event_enable,
	output logic magic_wake_enable,
	output logic [7:0] wake_filter,
	output logic phy_low_power,
	output logic datapath_enable,
	output logic rx_discard,
	output logic minimal_power_disable_mode
);
	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	logic io_rst_meta, io_rst_sync, io_rst_prev;
	logic msg_meta, msg_sync, msg_prev;
	logic io_rst_rise, io_rst_fall, msg_rise;
	logic [fn_power_pkg::OUTST_W-1:0] outstanding;
	logic drain_pending, blocked, entering_d3;

	// two synchroniser flops and one edge-detect flop for each of the i/o reset and the reset-held message pins
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			io_rst_meta <= 1'b0;
			io_rst_sync <= 1'b0;
			io_rst_prev <= 1'b0;
			msg_meta <= 1'b0;
			msg_sync <= 1'b0;
			msg_prev <= 1'b0;
		end else begin
			io_rst_meta <= io_reset_n;
			io_rst_sync <= io_rst_meta;
			io_rst_prev <= io_rst_sync;
			msg_meta <= reset_held_msg;
			msg_sync <= msg_meta;
			msg_prev <= msg_sync;
		end
	end
	assign io_rst_rise = io_rst_sync & ~io_rst_prev;
	assign io_rst_fall = ~io_rst_sync & io_rst_prev;
	assign msg_rise = msg_sync & ~msg_prev;
	assign entering_d3 = cfg_wr.pm_write && (cfg_wr.pm_state == fn_power_pkg::PS_D3)
		&& (power_state != fn_power_pkg::D3HOT_STATE) && (power_state != fn_power_pkg::RESET_HELD_STATE);

	// ----------------------------------------------------------------
	// power state machine
	// ----------------------------------------------------------------
	// power-good enters reset-held, i/o reset release leaves it
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			power_state <= fn_power_pkg::RESET_HELD_STATE;
		end else if (io_rst_fall) begin
			// i/o reset assertion from any state
			power_state <= fn_power_pkg::RESET_HELD_STATE;
		end else begin
			unique case (power_state)
				fn_power_pkg::RESET_HELD_STATE: begin
					if (io_rst_rise) begin
						power_state <= fn_power_pkg::UNINITIALIZED_ACTIVE_STATE;
					end
				end
				fn_power_pkg::UNINITIALIZED_ACTIVE_STATE: begin
					if (entering_d3) begin
						power_state <= fn_power_pkg::D3HOT_STATE;
					end else if (cfg_wr.cmd_write && (cfg_wr.mem_enable || cfg_wr.io_enable)) begin
						power_state <= fn_power_pkg::FULLY_ACTIVE_STATE;
					end
				end
				fn_power_pkg::FULLY_ACTIVE_STATE: begin
					if (entering_d3) begin
						power_state <= fn_power_pkg::D3HOT_STATE;
					end
				end
				fn_power_pkg::D3HOT_STATE: begin
					if (cfg_wr.pm_write && (cfg_wr.pm_state == fn_power_pkg::PS_D0)) begin
						power_state <= fn_power_pkg::UNINITIALIZED_ACTIVE_STATE;
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// command register bits
	// ----------------------------------------------------------------
	// access enables cleared on d3 entry; likewise when all in d3
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			mem_enable <= 1'b0;
			io_enable <= 1'b0;
			bus_master <= 1'b0;
		end else if (io_rst_fall || entering_d3 || (power_state == fn_power_pkg::D3HOT_STATE && other_functions_d3)) begin
			mem_enable <= 1'b0;
			io_enable <= 1'b0;
			bus_master <= bus_master && !io_rst_fall;
		end else if (cfg_wr.cmd_write && power_state != fn_power_pkg::D3HOT_STATE) begin
			mem_enable <= cfg_wr.mem_enable;
			io_enable <= cfg_wr.io_enable;
			bus_master <= cfg_wr.bus_master;
		end
	end

	// ----------------------------------------------------------------
	// master disable handshake
	// ----------------------------------------------------------------
	// any reset level clears master disable
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			master_disable <= 1'b0;
		end else if (sw_reset || io_rst_fall) begin
			master_disable <= 1'b0;
		end else if (master_disable_wr) begin
			master_disable <= master_disable_val;
		end
	end

	// count issued requests awaiting completions
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			outstanding <= fn_power_pkg::OUTST_ZERO;
		end else if (master_grant && !completion_in) begin
			outstanding <= outstanding + fn_power_pkg::OUTST_ONE;
		end else if (!master_grant && completion_in && outstanding != fn_power_pkg::OUTST_ZERO) begin
			outstanding <= outstanding - fn_power_pkg::OUTST_ONE;
		end
	end
	assign drain_pending = (outstanding != fn_power_pkg::OUTST_ZERO) || (|engine_req);
	// no new master cycles in d3, without bus master or under master disable
	assign blocked = (power_state == fn_power_pkg::D3HOT_STATE) || !bus_master || master_disable
		|| (power_state == fn_power_pkg::RESET_HELD_STATE) || !tlp_schedule_enable;

	// only new grants stop; requests already issued still complete
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			master_grant <= 1'b0;
		end else begin
			master_grant <= master_issue && !blocked && (|engine_req);
		end
	end

	// status clears only when disabled and fully drained
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			master_enable_status <= 1'b1;
		end else begin
			master_enable_status <= !(master_disable && !drain_pending && !master_grant);
		end
	end

	// ----------------------------------------------------------------
	// tlp scheduling and ready-for-reset exchange
	// ----------------------------------------------------------------
	logic rfr_wait;
	// stop new tlps, drain, answer non-posted, then ready
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tlp_schedule_enable <= 1'b1;
			rfr_wait <= 1'b0;
			ready_for_reset_msg <= 1'b0;
		end else begin
			ready_for_reset_msg <= 1'b0;
			if (io_rst_rise) begin
				tlp_schedule_enable <= 1'b1;
				rfr_wait <= 1'b0;
			end else if (msg_rise) begin
				tlp_schedule_enable <= 1'b0;
				rfr_wait <= 1'b1;
			end else if (rfr_wait && outstanding == fn_power_pkg::OUTST_ZERO && !np_pending && !master_grant) begin
				rfr_wait <= 1'b0;
				ready_for_reset_msg <= 1'b1;
			end else if (power_state == fn_power_pkg::D3HOT_STATE && cfg_wr.pm_write
				&& cfg_wr.pm_state == fn_power_pkg::PS_D0) begin
				tlp_schedule_enable <= 1'b1; // d3 exit or i/o reset release resumes; after the ready message it stays off
			end else if (power_state == fn_power_pkg::D3HOT_STATE && other_functions_d3) begin
				tlp_schedule_enable <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// received tlp checking in d3hot
	// ----------------------------------------------------------------
	logic bad_req, bad_cpl;
	assign bad_req = rx_tlp.valid && !rx_tlp.is_completion && !rx_tlp.is_config && !rx_tlp.is_message;
	assign bad_cpl = rx_tlp.valid && rx_tlp.is_completion;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			unsupported_request <= 1'b0;
			unexpected_completion <= 1'b0;
			error_msg_send <= 1'b0;
		end else begin
			unsupported_request <= (power_state == fn_power_pkg::D3HOT_STATE) && bad_req;
			unexpected_completion <= (power_state == fn_power_pkg::D3HOT_STATE) && bad_cpl;
			error_msg_send <= (power_state == fn_power_pkg::D3HOT_STATE) && bad_req && error_report_enable;
		end
	end

	// ----------------------------------------------------------------
	// wake configuration
	// ----------------------------------------------------------------
	// filters kept over d3 and reset-held; wake event enable and filters cleared on d0u entry, magic wake kept
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wake_event_enable <= 1'b0;
			magic_wake_enable <= 1'b0;
			wake_filter <= 8'h00;
		end else if (io_rst_rise || (power_state == fn_power_pkg::D3HOT_STATE && cfg_wr.pm_write
			&& cfg_wr.pm_state == fn_power_pkg::PS_D0)) begin
			wake_event_enable <= 1'b0;
			wake_filter <= 8'h00;
			magic_wake_enable <= magic_wake_enable;
		end else begin
			// flash loads magic wake at power-up
			if (flash_cfg.valid && power_state == fn_power_pkg::RESET_HELD_STATE) begin
				magic_wake_enable <= flash_cfg.flash_magic_wake_enable;
			end else if (magic_wake_enable_wr) begin
				magic_wake_enable <= magic_wake_enable_val;
			end
			if (wake_event_enable_wr) begin
				wake_event_enable <= wake_event_enable_val;
			end
			if (wake_filter_wr) begin
				wake_filter <= wake_filter_wr_val;
			end
		end
	end

	// ----------------------------------------------------------------
	// datapath, phy and disable mode
	// ----------------------------------------------------------------
	logic mng_none;
	assign mng_none = !flash_cfg.flash_manageability_enable
		&& (flash_cfg.manageability_mode == fn_power_pkg::MNG_MODE_NONE);
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			minimal_power_disable_mode <= 1'b0;
			phy_low_power <= 1'b1;
			datapath_enable <= 1'b0;
			rx_discard <= 1'b0;
		end else begin
			// enter in reset-held without wake or manageability, leave on release
			if (io_rst_rise) begin
				minimal_power_disable_mode <= 1'b0;
			end else if (power_state == fn_power_pkg::RESET_HELD_STATE && !io_rst_sync && flash_cfg.valid
				&& !flash_cfg.flash_magic_wake_enable && !magic_wake_enable && !wake_event_enable && mng_none) begin
				minimal_power_disable_mode <= 1'b1;
			end
			// phys low power outside active; datapath on in active
			phy_low_power <= (power_state != fn_power_pkg::FULLY_ACTIVE_STATE);
			datapath_enable <= (power_state == fn_power_pkg::FULLY_ACTIVE_STATE);
			// held rx packets discarded on d3 exit
			rx_discard <= (power_state == fn_power_pkg::D3HOT_STATE) && cfg_wr.pm_write
				&& (cfg_wr.pm_state == fn_power_pkg::PS_D0);
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	property p_d3_entry;
		@(posedge core_clk) disable iff (!rst_n) (entering_d3 && !io_rst_fall) |=> power_state == fn_power_pkg::D3HOT_STATE;
	endproperty
	a_d3_entry: assert property (p_d3_entry) else $error("d3 write did not enter d3hot");
	property p_d3_clears_enables;
		@(posedge core_clk) disable iff (!rst_n) (entering_d3) |=> !mem_enable && !io_enable;
	endproperty
	a_d3_clears_enables: assert property (p_d3_clears_enables) else $error("access enables kept on d3");
	property p_no_master_in_d3;
		@(posedge core_clk) disable iff (!rst_n) $past(power_state == fn_power_pkg::D3HOT_STATE) |-> !master_grant;
	endproperty
	a_no_master_in_d3: assert property (p_no_master_in_d3) else $error("master cycle in d3hot");
	property p_ur_in_d3;
		@(posedge core_clk) disable iff (!rst_n) (power_state == fn_power_pkg::D3HOT_STATE && bad_req) |=> unsupported_request;
	endproperty
	a_ur_in_d3: assert property (p_ur_in_d3) else $error("request not flagged unsupported");
	property p_d0_exit;
		@(posedge core_clk) disable iff (!rst_n) (power_state == fn_power_pkg::D3HOT_STATE && cfg_wr.pm_write
			&& cfg_wr.pm_state == fn_power_pkg::PS_D0 && !io_rst_fall) |=> power_state == fn_power_pkg::UNINITIALIZED_ACTIVE_STATE;
	endproperty
	a_d0_exit: assert property (p_d0_exit) else $error("d0 write did not leave d3hot");
	property p_io_reset_held;
		@(posedge core_clk) disable iff (!rst_n) io_rst_fall |=> power_state == fn_power_pkg::RESET_HELD_STATE;
	endproperty
	a_io_reset_held: assert property (p_io_reset_held) else $error("i/o reset did not enter reset-held");
	property p_status_clear;
		@(posedge core_clk) disable iff (!rst_n) !master_enable_status |-> $past(master_disable);
	endproperty
	a_status_clear: assert property (p_status_clear) else $error("status cleared without master disable");
	property p_sw_reset_clears;
		@(posedge core_clk) disable iff (!rst_n) sw_reset |=> !master_disable;
	endproperty
	a_sw_reset_clears: assert property (p_sw_reset_clears) else $error("master disable survived reset");
	property p_ignore_other;
		@(posedge core_clk) disable iff (!rst_n) (cfg_wr.pm_write && cfg_wr.pm_state != fn_power_pkg::PS_D0
			&& cfg_wr.pm_state != fn_power_pkg::PS_D3 && !io_rst_fall && !io_rst_rise && !cfg_wr.cmd_write)
			|=> $stable(power_state);
	endproperty
	a_ignore_other: assert property (p_ignore_other) else $error("illegal power state write acted");
endmodule : function_power_state_control

/* File: dv/host_link_model.sv */
// partner model: host root complex that answers the function's master requests
// assumes one completion per master_grant pulse, all on core_clk
`timescale 1ns/1ps

module host_link_model (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic slow,
	input wire logic master_grant,
	output logic completion_in
);
	int pend;
	int tmr;

	// ----------------------------------------
	// completion return
	// ----------------------------------------
	// each granted request is answered after a short or a long delay
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pend <= 0;
			tmr <= 0;
			completion_in <= 1'b0;
		end else begin
			completion_in <= 1'b0;
			if (pend > 0 && tmr >= (slow ? 12 : 2)) begin
				completion_in <= 1'b1;
				tmr <= 0;
				pend <= pend - 1 + (master_grant ? 1 : 0);
			end else begin
				tmr <= (pend > 0) ? tmr + 1 : 0;
				pend <= pend + (master_grant ? 1 : 0);
			end
		end
	end
endmodule : host_link_model

/* File: dv/function_power_state_control_tb_top.sv */
// testbench: walks the function through power-up, D0, master disable, D3 and reset-held
// assumes the host_link_model partner and the design package fn_power_pkg
`timescale 1ns/1ps
`define CHK(got, exp, msg) begin total_checks++; if ((got) !== (exp)) begin err_total++; \
	$display("MISMATCH t=%0t %s", $time, msg); end end

module function_power_state_control_tb_top;
	logic core_clk, rst_n, io_reset_n, sw_reset, master_disable_wr, master_disable_val, slow;
	logic wake_event_enable_wr, wake_event_enable_val, magic_wake_enable_wr, magic_wake_enable_val;
	logic wake_filter_wr, error_report_enable, other_functions_d3, reset_held_msg, master_issue;
	logic completion_in, np_pending, mem_enable, io_enable, bus_master, master_disable;
	logic master_enable_status, master_grant, tlp_schedule_enable, unsupported_request;
	logic unexpected_completion, error_msg_send, ready_for_reset_msg, wake_event_enable;
	logic magic_wake_enable, phy_low_power, datapath_enable, rx_discard, minimal_power_disable_mode;
	logic [7:0] wake_filter_wr_val, wake_filter;
	logic [1:0] engine_req;
	fn_power_pkg::cfg_write_t cfg_wr;
	fn_power_pkg::rx_tlp_t rx_tlp;
	fn_power_pkg::flash_cfg_t flash_cfg;
	fn_power_pkg::power_state_t power_state;
	int err_total = 0;
	int total_checks = 0;
	int grants = 0;
	int readies = 0;
	int cmpls = 0;
	int n;

	function_power_state_control #(.ENGINES(2)) dut (.core_clk, .rst_n, .io_reset_n, .sw_reset, .cfg_wr,
		.master_disable_wr, .master_disable_val, .wake_event_enable_wr, .wake_event_enable_val,
		.magic_wake_enable_wr, .magic_wake_enable_val, .wake_filter_wr_val, .wake_filter_wr,
		.error_report_enable, .rx_tlp, .flash_cfg, .other_functions_d3, .reset_held_msg, .engine_req,
		.master_issue, .completion_in, .np_pending, .power_state, .mem_enable, .io_enable, .bus_master,
		.master_disable, .master_enable_status, .master_grant, .tlp_schedule_enable, .unsupported_request,
		.unexpected_completion, .error_msg_send, .ready_for_reset_msg, .wake_event_enable,
		.magic_wake_enable, .wake_filter, .phy_low_power, .datapath_enable, .rx_discard,
		.minimal_power_disable_mode);

	host_link_model partner (.core_clk, .rst_n, .slow, .master_grant, .completion_in);

	// ----------------------------------------
	// clock, event counters and helpers
	// ----------------------------------------
	always #2.5 core_clk = ~core_clk;

	// count output pulses seen at each edge
	always @(posedge core_clk) begin
		if (master_grant === 1'b1) grants++;
		if (ready_for_reset_msg === 1'b1) readies++;
		if (completion_in === 1'b1) cmpls++;
	end

	task tick(input int k);
		repeat (k) @(posedge core_clk);
		#1;
	endtask : tick

	// one-cycle write of the power-state field
	task pm(input logic [1:0] s);
		@(posedge core_clk);
		cfg_wr.pm_write <= 1'b1;
		cfg_wr.pm_state <= s;
		@(posedge core_clk);
		cfg_wr.pm_write <= 1'b0;
		#1;
	endtask : pm

	// one-cycle write of the command register
	task cmd(input logic m, input logic b);
		@(posedge core_clk);
		cfg_wr.cmd_write <= 1'b1;
		cfg_wr.mem_enable <= m;
		cfg_wr.bus_master <= b;
		@(posedge core_clk);
		cfg_wr.cmd_write <= 1'b0;
		#1;
	endtask : cmd

	task summarize;
		$display("errors %0d of %0d checks", err_total, total_checks);
		if (err_total == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : summarize

	initial begin
		#60000;
		err_total++;
		summarize();
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		{core_clk, rst_n, io_reset_n, sw_reset, master_disable_wr, master_disable_val, slow} = '0;
		{wake_event_enable_wr, wake_event_enable_val, magic_wake_enable_wr, magic_wake_enable_val} = '0;
		{wake_filter_wr, other_functions_d3, reset_held_msg, master_issue, np_pending} = '0;
		error_report_enable = 1'b1;
		wake_filter_wr_val = 8'hA5;
		engine_req = 2'h0;
		cfg_wr = '0;
		rx_tlp = '0;
		flash_cfg = '{1'b1, 1'b0, 1'b0, fn_power_pkg::MNG_MODE_NONE};
		tick(2);
		@(posedge core_clk) rst_n <= 1'b1;
		tick(4);
		`CHK(power_state, fn_power_pkg::RESET_HELD_STATE, "not reset-held at power-up")
		`CHK(phy_low_power, 1'b1, "phy not low power")
		`CHK(minimal_power_disable_mode, 1'b1, "disable mode not entered")
		`CHK(magic_wake_enable, 1'b0, "magic wake not taken from flash")
		@(posedge core_clk) io_reset_n <= 1'b1;
		tick(6);
		`CHK(power_state, fn_power_pkg::UNINITIALIZED_ACTIVE_STATE, "no D0u after io reset")
		`CHK(minimal_power_disable_mode, 1'b0, "disable mode kept")
		pm(2'h1);
		`CHK(power_state, fn_power_pkg::UNINITIALIZED_ACTIVE_STATE, "reserved encoding taken")
		cmd(1'b1, 1'b1);
		`CHK(power_state, fn_power_pkg::FULLY_ACTIVE_STATE, "no D0a on enable")
		`CHK(bus_master, 1'b1, "bus master not set")
		slow <= 1'b1;
		@(posedge core_clk) engine_req <= 2'h1;
		master_issue <= 1'b1;
		n = grants;
		tick(3);
		`CHK(grants > n, 1'b1, "no grant while enabled")
		`CHK({datapath_enable, phy_low_power}, 2'h2, "datapath or phy wrong in D0a")
		@(posedge core_clk) master_disable_wr <= 1'b1;
		master_disable_val <= 1'b1;
		@(posedge core_clk) master_disable_wr <= 1'b0;
		tick(2);
		n = grants;
		tick(4);
		`CHK(grants, n, "grant while disabled")
		`CHK(master_enable_status, 1'b1, "status low with engines busy")
		@(posedge core_clk) engine_req <= 2'h0;
		master_issue <= 1'b0;
		n = cmpls;
		// bounded poll stands in for the driver timeout
		for (int i = 0; i < 60 && master_enable_status !== 1'b0; i++) tick(1);
		`CHK(master_enable_status, 1'b0, "status never cleared")
		`CHK(cmpls > n, 1'b1, "status cleared before completion")
		@(posedge core_clk) sw_reset <= 1'b1;
		@(posedge core_clk) sw_reset <= 1'b0;
		tick(3);
		`CHK(master_disable, 1'b0, "disable survived sw reset")
		`CHK(master_enable_status, 1'b1, "status not set again")
		@(posedge core_clk) wake_filter_wr <= 1'b1;
		wake_event_enable_wr <= 1'b1;
		wake_event_enable_val <= 1'b1;
		@(posedge core_clk) wake_filter_wr <= 1'b0;
		wake_event_enable_wr <= 1'b0;
		pm(fn_power_pkg::PS_D3);
		`CHK(power_state, fn_power_pkg::D3HOT_STATE, "no D3hot")
		`CHK({mem_enable, io_enable}, 2'h0, "enables kept in D3")
		`CHK(wake_filter, 8'hA5, "filter lost in D3")
		`CHK(wake_event_enable, 1'b1, "wake enable lost in D3")
		@(posedge core_clk) other_functions_d3 <= 1'b1;
		// config, message, request, request with reporting off, completion
		for (int k = 0; k < 5; k++) begin
			@(posedge core_clk) rx_tlp <= '{1'b1, k == 0, k == 1, k == 4};
			error_report_enable <= (k != 3);
			@(posedge core_clk) rx_tlp.valid <= 1'b0;
			#1;
			`CHK(unsupported_request, k == 2 || k == 3, "unsupported flag wrong")
			`CHK(unexpected_completion, k == 4, "unexpected completion flag wrong")
			`CHK(error_msg_send, k == 2, "error message wrong")
		end
		@(posedge core_clk) engine_req <= 2'h3;
		master_issue <= 1'b1;
		n = grants;
		tick(5);
		`CHK(grants, n, "master cycle in D3")
		`CHK(tlp_schedule_enable, 1'b0, "scheduling on with all in D3")
		@(posedge core_clk) engine_req <= 2'h0;
		master_issue <= 1'b0;
		other_functions_d3 <= 1'b0;
		pm(fn_power_pkg::PS_D0);
		`CHK(power_state, fn_power_pkg::UNINITIALIZED_ACTIVE_STATE, "no D0u from D3")
		`CHK(rx_discard, 1'b1, "held packets not dropped")
		`CHK(tlp_schedule_enable, 1'b1, "scheduling not resumed on D3 exit")
		`CHK(wake_event_enable, 1'b0, "wake not disabled in D0u")
		cmd(1'b1, 1'b1);
		@(posedge core_clk) np_pending <= 1'b1;
		reset_held_msg <= 1'b1;
		n = readies;
		tick(8);
		`CHK(tlp_schedule_enable, 1'b0, "scheduling not stopped")
		`CHK(readies, n, "ready sent with request pending")
		@(posedge core_clk) np_pending <= 1'b0;
		tick(10);
		`CHK(readies, n + 1, "ready not sent once")
		`CHK(tlp_schedule_enable, 1'b0, "scheduling resumed after ready")
		@(posedge core_clk) reset_held_msg <= 1'b0;
		pm(fn_power_pkg::PS_D3);
		@(posedge core_clk) io_reset_n <= 1'b0;
		tick(6);
		`CHK(power_state, fn_power_pkg::RESET_HELD_STATE, "no reset-held from D3")
		summarize();
	end
endmodule : function_power_state_control_tb_top
